// ==== core/duart_channel_reset_state.sv ====
// Dual channel register bank with power-up and pin reset states, reached over APB.
//
// Function
// - Divisors load low 0x01, high 0x00 only at power-up
// - Modem deltas clear; upper bits show inverted inputs
// - Interrupt source reads 0x01 after reset
// - Line status reads 0x60 after reset
// - Scratchpad loads all ones on reset
// - Enhanced mode select loads 0x80 on reset
// - Other control registers clear to zero
// - Holding registers have no defined reset value
// - Idle pins driven high during and after reset
// - Transmit ready low, interrupt pin undriven
// - Enhanced enable gates enhanced bits; reset clears
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module duart_channel_reset_state
(
   // Clock and power-up reset
   input  wire logic                                          pclk,
   input  wire logic                                          presetn,
   // Hardware reset pin, active low, synchronous
   input  wire logic                                          hw_reset_n,
   // APB slave
   input  wire logic                                          psel,
   input  wire logic                                          penable,
   input  wire logic                                          pwrite,
   input  wire logic [11:0]                                   paddr,
   input  wire logic [31:0]                                   pwdata,
   output var  logic                                          pready,
   output var  logic [31:0]                                   prdata,
   output var  logic                                          pslverr,
   // Modem inputs per channel
   input  wire duart_reset_pkg::modem_in_t [duart_reset_pkg::CHANNELS-1:0] modem_in,
   // Channel pins
   output var  duart_reset_pkg::pins_t [duart_reset_pkg::CHANNELS-1:0]     pins,
   // Combined interrupt
   output var  logic                                          irq
);

   // ==========================================================================
   // State
   // ==========================================================================
   duart_reset_pkg::state_t st;
   duart_reset_pkg::state_t next_st;
   logic [7:0]              source [duart_reset_pkg::CHANNELS];
   logic [7:0]              mstat  [duart_reset_pkg::CHANNELS];

   logic       setup;
   logic       access;
   logic       chan_sel;
   logic [4:0] index;
   logic       bad_addr;

   assign setup    = psel && !penable;
   assign access   = psel && penable && st.pready;
   assign chan_sel = paddr[duart_reset_pkg::CHAN_BIT];
   assign index    = paddr[duart_reset_pkg::INDEX_HI:duart_reset_pkg::INDEX_LO];
   assign bad_addr = (paddr[11:8] != 4'h0) || (paddr[1:0] != 2'h0) || (index > duart_reset_pkg::IDX_LAST);

   // Source and status views are derived from stored state and the modem inputs, so they need no reset of their own.
   always_comb
   begin
      for (int c = 0; c < duart_reset_pkg::CHANNELS; c++)
      begin
         if (st.ch[c].int_enable[duart_reset_pkg::MODEM_INT_BIT] && (st.ch[c].modem_delta != 4'h0))
         begin
            source[c] = duart_reset_pkg::SOURCE_MODEM;
         end
         else
         begin
            source[c] = duart_reset_pkg::SOURCE_NONE;
         end
         source[c][7:6] = {2{st.ch[c].fifo_control[0]}};
         mstat[c] = {~modem_in[c], st.ch[c].modem_delta};
      end
   end

   // ==========================================================================
   // Next state
   // ==========================================================================
   always_comb
   begin
      logic [3:0] cur;
      logic [3:0] chg;
      logic [7:0] rd;
      logic [7:0] wd;
      logic       hit;
      cur = 4'h0;
      chg = 4'h0;
      rd  = 8'h00;
      wd  = pwdata[7:0];
      hit = 1'b0;
      next_st = st;
      next_st.pready  = 1'b0;
      next_st.pslverr = 1'b0;

      for (int c = 0; c < duart_reset_pkg::CHANNELS; c++)
      begin
         hit = (chan_sel == c[0]) && !bad_addr;
         cur = ~modem_in[c];
         if (st.ch[c].modem_primed)
         begin
            chg = {st.ch[c].modem_prev[3] ^ cur[3], st.ch[c].modem_prev[2] & ~cur[2],
                   st.ch[c].modem_prev[1] ^ cur[1], st.ch[c].modem_prev[0] ^ cur[0]};
         end
         else
         begin
            chg = 4'h0;
         end
         next_st.ch[c].modem_prev   = cur;
         next_st.ch[c].modem_primed = 1'b1;

         // Reads clear only the bits that were returned, so an event landing mid-transfer survives.
         if (access && !pwrite && hit && (index == duart_reset_pkg::IDX_MODEM_STATUS))
         begin
            next_st.ch[c].modem_delta = st.ch[c].modem_delta & ~st.prdata[3:0];
         end
         if (access && !pwrite && hit && (index == duart_reset_pkg::IDX_EVENT_STATUS))
         begin
            next_st.ch[c].event_status = st.ch[c].event_status & ~st.prdata[3:0];
         end
         next_st.ch[c].modem_delta  = next_st.ch[c].modem_delta | chg;
         next_st.ch[c].event_status = next_st.ch[c].event_status | chg;

         if (access && pwrite && hit)
         begin
            unique case (index)
               duart_reset_pkg::IDX_HOLDING:       next_st.ch[c].transmit_hold = wd;
               duart_reset_pkg::IDX_INT_ENABLE:
                  next_st.ch[c].int_enable = st.ch[c].enh_feature[duart_reset_pkg::ENH_ENABLE_BIT] ? wd :
                     ((st.ch[c].int_enable & duart_reset_pkg::IER_ENH_MASK) | (wd & ~duart_reset_pkg::IER_ENH_MASK));
               duart_reset_pkg::IDX_FIFO_CONTROL:
                  next_st.ch[c].fifo_control = st.ch[c].enh_feature[duart_reset_pkg::ENH_ENABLE_BIT] ? wd :
                     ((st.ch[c].fifo_control & duart_reset_pkg::FCR_ENH_MASK) | (wd & ~duart_reset_pkg::FCR_ENH_MASK));
               duart_reset_pkg::IDX_LINE_CONTROL:  next_st.ch[c].line_control = wd;
               duart_reset_pkg::IDX_MODEM_CONTROL:
                  next_st.ch[c].modem_control = st.ch[c].enh_feature[duart_reset_pkg::ENH_ENABLE_BIT] ? wd :
                     ((st.ch[c].modem_control & duart_reset_pkg::MCR_ENH_MASK) | (wd & ~duart_reset_pkg::MCR_ENH_MASK));
               duart_reset_pkg::IDX_SCRATCHPAD:    next_st.ch[c].scratchpad = wd;
               duart_reset_pkg::IDX_ENH_MODE_SEL:  next_st.ch[c].enh_mode_select = wd;
               duart_reset_pkg::IDX_ENH_FEATURE:   next_st.ch[c].enh_feature = wd;
               duart_reset_pkg::IDX_RESUME_ONE:    next_st.ch[c].resume_one = wd;
               duart_reset_pkg::IDX_RESUME_TWO:    next_st.ch[c].resume_two = wd;
               duart_reset_pkg::IDX_PAUSE_ONE:     next_st.ch[c].pause_one = wd;
               duart_reset_pkg::IDX_PAUSE_TWO:     next_st.ch[c].pause_two = wd;
               duart_reset_pkg::IDX_TRIGGER_LEVEL: next_st.ch[c].trigger_level = wd;
               duart_reset_pkg::IDX_DIV_LOW:       next_st.ch[c].div_low = wd;
               duart_reset_pkg::IDX_DIV_HIGH:      next_st.ch[c].div_high = wd;
               duart_reset_pkg::IDX_DIV_FRACTION:
                  if (st.ch[c].enh_feature[duart_reset_pkg::ENH_ENABLE_BIT])
                  begin
                     next_st.ch[c].div_fraction = wd;
                  end
               duart_reset_pkg::IDX_EVENT_MASK:    next_st.ch[c].event_mask = wd[3:0];
               default:                            next_st.ch[c].line_status = st.ch[c].line_status;
            endcase
         end

         next_st.pin[c].tx                   = 1'b1;
         next_st.pin[c].general_output_two_n = ~st.ch[c].modem_control[3];
         next_st.pin[c].rts_n                = ~st.ch[c].modem_control[1];
         next_st.pin[c].dtr_n                = ~st.ch[c].modem_control[0];
         next_st.pin[c].receive_ready_n      = 1'b1;
         next_st.pin[c].transmit_ready_n     = 1'b0;
         next_st.pin[c].int_out              = ~source[c][0];
         next_st.pin[c].int_oe               = st.ch[c].modem_control[3];

         // The pin reset keeps the divisor low and high bytes; only the power-up reset loads them.
         if (!hw_reset_n)
         begin
            next_st.ch[c] = duart_reset_pkg::CHAN_RST;
            next_st.ch[c].div_low  = st.ch[c].div_low;
            next_st.ch[c].div_high = st.ch[c].div_high;
            next_st.pin[c] = duart_reset_pkg::PINS_RST;
         end
      end

      // Receive holding has no datapath behind it and reads zero; software must not rely on it.
      unique case (index)
         duart_reset_pkg::IDX_HOLDING:       rd = 8'h00;
         duart_reset_pkg::IDX_INT_ENABLE:    rd = st.ch[chan_sel].int_enable;
         duart_reset_pkg::IDX_INT_SOURCE:    rd = source[chan_sel];
         duart_reset_pkg::IDX_LINE_CONTROL:  rd = st.ch[chan_sel].line_control;
         duart_reset_pkg::IDX_MODEM_CONTROL: rd = st.ch[chan_sel].modem_control;
         duart_reset_pkg::IDX_LINE_STATUS:   rd = st.ch[chan_sel].line_status;
         duart_reset_pkg::IDX_MODEM_STATUS:  rd = mstat[chan_sel];
         duart_reset_pkg::IDX_SCRATCHPAD:    rd = st.ch[chan_sel].scratchpad;
         duart_reset_pkg::IDX_FIFO_LEVEL:    rd = st.ch[chan_sel].fifo_level;
         duart_reset_pkg::IDX_ENH_FEATURE:   rd = st.ch[chan_sel].enh_feature;
         duart_reset_pkg::IDX_RESUME_ONE:    rd = st.ch[chan_sel].resume_one;
         duart_reset_pkg::IDX_RESUME_TWO:    rd = st.ch[chan_sel].resume_two;
         duart_reset_pkg::IDX_PAUSE_ONE:     rd = st.ch[chan_sel].pause_one;
         duart_reset_pkg::IDX_PAUSE_TWO:     rd = st.ch[chan_sel].pause_two;
         duart_reset_pkg::IDX_TRIGGER_LEVEL: rd = st.ch[chan_sel].trigger_level;
         duart_reset_pkg::IDX_DIV_LOW:       rd = st.ch[chan_sel].div_low;
         duart_reset_pkg::IDX_DIV_HIGH:      rd = st.ch[chan_sel].div_high;
         duart_reset_pkg::IDX_DIV_FRACTION:  rd = st.ch[chan_sel].div_fraction;
         duart_reset_pkg::IDX_EVENT_STATUS:  rd = {4'h0, st.ch[chan_sel].event_status};
         duart_reset_pkg::IDX_EVENT_MASK:    rd = {4'h0, st.ch[chan_sel].event_mask};
         default:                            rd = 8'h00;
      endcase

      if (setup)
      begin
         next_st.pready  = 1'b1;
         next_st.pslverr = bad_addr;
         next_st.prdata  = (bad_addr || pwrite) ? 32'h0000_0000 : {24'h00_0000, rd};
      end

      next_st.irq = 1'b0;
      for (int c = 0; c < duart_reset_pkg::CHANNELS; c++)
      begin
         next_st.irq = next_st.irq | (|(next_st.ch[c].event_status & next_st.ch[c].event_mask));
      end
   end

   // Power-up reset loads every field, divisors included.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st <= duart_reset_pkg::STATE_RST;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign pready  = st.pready;
   assign prdata  = st.prdata;
   assign pslverr = st.pslverr;
   assign pins    = st.pin;
   assign irq     = st.irq;

   // ==========================================================================
   // Assertions
   // ==========================================================================
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_div_keep;
      !hw_reset_n |=> $stable(st.ch[0].div_low) && $stable(st.ch[0].div_high);
   endproperty
   a_div_keep: assert property (p_div_keep) else $error("divisor changed by pin reset");

   property p_msr_reset;
      !hw_reset_n ##1 hw_reset_n |-> (mstat[0][3:0] == 4'h0) && (mstat[0][7:4] == ~modem_in[0]);
   endproperty
   a_msr_reset: assert property (p_msr_reset) else $error("modem status wrong after reset");

   property p_source_reset;
      !hw_reset_n |=> source[0] == 8'h01;
   endproperty
   a_source_reset: assert property (p_source_reset) else $error("interrupt source not 0x01");

   property p_line_status;
      !hw_reset_n |=> st.ch[0].line_status == 8'h60;
   endproperty
   a_line_status: assert property (p_line_status) else $error("line status not 0x60");

   property p_scratch;
      !hw_reset_n |=> (st.ch[0].scratchpad == 8'hff) && (st.ch[1].scratchpad == 8'hff);
   endproperty
   a_scratch: assert property (p_scratch) else $error("scratchpad not all ones");

   property p_mode_select;
      !hw_reset_n |=> st.ch[1].enh_mode_select == 8'h80;
   endproperty
   a_mode_select: assert property (p_mode_select) else $error("mode select not 0x80");

   property p_clear;
      !hw_reset_n |=> (st.ch[0].int_enable == 8'h00) && (st.ch[0].modem_control == 8'h00)
                      && (st.ch[0].enh_feature == 8'h00) && (st.ch[0].div_fraction == 8'h00);
   endproperty
   a_clear: assert property (p_clear) else $error("control register not cleared");

   property p_pins_high;
      !hw_reset_n |=> pins[0].tx && pins[0].general_output_two_n && pins[0].rts_n && pins[0].dtr_n
                      && pins[0].receive_ready_n;
   endproperty
   a_pins_high: assert property (p_pins_high) else $error("idle pin not high");

   property p_pins_low;
      !hw_reset_n |=> !pins[1].transmit_ready_n && !pins[1].int_oe;
   endproperty
   a_pins_low: assert property (p_pins_low) else $error("transmit ready or interrupt pin wrong");

   property p_gate;
      access && pwrite && !bad_addr && !chan_sel && (index == duart_reset_pkg::IDX_INT_ENABLE)
         && !st.ch[0].enh_feature[4] && hw_reset_n |=> $stable(st.ch[0].int_enable[7:4]);
   endproperty
   a_gate: assert property (p_gate) else $error("enhanced enable bits written while locked");

   property p_irq;
      ##1 irq == ((|(st.ch[0].event_status & st.ch[0].event_mask)) | (|(st.ch[1].event_status & st.ch[1].event_mask)));
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt output disagrees with status");

   property p_ready_pulse;
      setup |=> pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("no answer after setup");

   property p_ready_drop;
      pready |=> !pready;
   endproperty
   a_ready_drop: assert property (p_ready_drop) else $error("pready held too long");

   property p_slverr;
      setup && bad_addr
         |=> pslverr && (prdata == 32'h0000_0000);
   endproperty
   a_slverr: assert property (p_slverr) else $error("unmapped address not refused");

   property p_div_keep_b;
      !hw_reset_n
         |=> $stable(st.ch[1].div_low) && $stable(st.ch[1].div_high);
   endproperty
   a_div_keep_b: assert property (p_div_keep_b) else $error("divisor changed by pin reset");

   property p_source_reset_b;
      !hw_reset_n |=> source[1] == 8'h01;
   endproperty
   a_source_reset_b: assert property (p_source_reset_b) else $error("interrupt source not 0x01");

   property p_pins_low_a;
      !hw_reset_n |=> !pins[0].transmit_ready_n && !pins[0].int_oe;
   endproperty
   a_pins_low_a: assert property (p_pins_low_a) else $error("transmit ready or interrupt pin wrong");

   property p_irq_reset;
      !hw_reset_n |=> !irq;
   endproperty
   a_irq_reset: assert property (p_irq_reset) else $error("interrupt left after pin reset");

   property p_frac_gate;
      access && pwrite && !bad_addr && !chan_sel && (index == duart_reset_pkg::IDX_DIV_FRACTION)
         && !st.ch[0].enh_feature[4] && hw_reset_n |=> $stable(st.ch[0].div_fraction);
   endproperty
   a_frac_gate: assert property (p_frac_gate) else $error("fraction written while locked");

   c_hw_reset: cover property (!hw_reset_n ##1 hw_reset_n);
   c_enh_write: cover property (access && pwrite && st.ch[0].enh_feature[4] && (index == duart_reset_pkg::IDX_INT_ENABLE));
   c_irq_clear: cover property (irq ##1 access && !pwrite && (index == duart_reset_pkg::IDX_EVENT_STATUS) ##1 !irq);
   c_unmapped: cover property (pready && pslverr);
   c_frac_write: cover property (access && pwrite && (index == duart_reset_pkg::IDX_DIV_FRACTION));

endmodule

`default_nettype wire

// ==== shared/duart_reset_pkg.sv ====
// Package with register map, reset values and carrier types of the dual channel register bank.
package duart_reset_pkg;

   // ==========================================================================
   // Geometry
   // ==========================================================================
   localparam int unsigned CHANNELS   = 2;
   localparam int unsigned CHAN_BIT   = 7;
   localparam int unsigned INDEX_HI   = 6;
   localparam int unsigned INDEX_LO   = 2;

   // ==========================================================================
   // Register indices; the byte address is channel * 0x80 + index * 4
   // ==========================================================================
   localparam logic [4:0] IDX_HOLDING       = 5'h00;
   localparam logic [4:0] IDX_INT_ENABLE    = 5'h01;
   localparam logic [4:0] IDX_FIFO_CONTROL  = 5'h02;
   localparam logic [4:0] IDX_INT_SOURCE    = 5'h03;
   localparam logic [4:0] IDX_LINE_CONTROL  = 5'h04;
   localparam logic [4:0] IDX_MODEM_CONTROL = 5'h05;
   localparam logic [4:0] IDX_LINE_STATUS   = 5'h06;
   localparam logic [4:0] IDX_MODEM_STATUS  = 5'h07;
   localparam logic [4:0] IDX_SCRATCHPAD    = 5'h08;
   localparam logic [4:0] IDX_ENH_MODE_SEL  = 5'h09;
   localparam logic [4:0] IDX_FIFO_LEVEL    = 5'h0a;
   localparam logic [4:0] IDX_ENH_FEATURE   = 5'h0b;
   localparam logic [4:0] IDX_RESUME_ONE    = 5'h0c;
   localparam logic [4:0] IDX_RESUME_TWO    = 5'h0d;
   localparam logic [4:0] IDX_PAUSE_ONE     = 5'h0e;
   localparam logic [4:0] IDX_PAUSE_TWO     = 5'h0f;
   localparam logic [4:0] IDX_TRIGGER_LEVEL = 5'h10;
   localparam logic [4:0] IDX_DIV_LOW       = 5'h11;
   localparam logic [4:0] IDX_DIV_HIGH      = 5'h12;
   localparam logic [4:0] IDX_DIV_FRACTION  = 5'h13;
   localparam logic [4:0] IDX_EVENT_STATUS  = 5'h14;
   localparam logic [4:0] IDX_EVENT_MASK    = 5'h15;
   localparam logic [4:0] IDX_LAST          = 5'h15;

   // ==========================================================================
   // Field positions and values
   // ==========================================================================
   localparam int unsigned ENH_ENABLE_BIT   = 4;
   localparam int unsigned MODEM_INT_BIT    = 3;
   localparam logic [7:0]  SOURCE_NONE      = 8'h01;
   localparam logic [7:0]  SOURCE_MODEM     = 8'h00;
   localparam logic [7:0]  IER_ENH_MASK     = 8'hf0;
   localparam logic [7:0]  FCR_ENH_MASK     = 8'h30;
   localparam logic [7:0]  MCR_ENH_MASK     = 8'he0;

   // ==========================================================================
   // Carriers
   // ==========================================================================
   typedef struct packed {
      logic cd_n;
      logic ri_n;
      logic dsr_n;
      logic cts_n;
   } modem_in_t;

   typedef struct packed {
      logic tx;
      logic general_output_two_n;
      logic rts_n;
      logic dtr_n;
      logic receive_ready_n;
      logic transmit_ready_n;
      logic int_out;
      logic int_oe;
   } pins_t;

   typedef struct packed {
      logic [7:0] div_low;
      logic [7:0] div_high;
      logic [7:0] div_fraction;
      logic [7:0] int_enable;
      logic [7:0] fifo_control;
      logic [7:0] line_control;
      logic [7:0] modem_control;
      logic [7:0] line_status;
      logic [3:0] modem_delta;
      logic [3:0] modem_prev;
      logic       modem_primed;
      logic [7:0] scratchpad;
      logic [7:0] enh_mode_select;
      logic [7:0] fifo_level;
      logic [7:0] enh_feature;
      logic [7:0] resume_one;
      logic [7:0] resume_two;
      logic [7:0] pause_one;
      logic [7:0] pause_two;
      logic [7:0] trigger_level;
      logic [7:0] transmit_hold;
      logic [3:0] event_status;
      logic [3:0] event_mask;
   } chan_t;

   typedef struct packed {
      chan_t [CHANNELS-1:0] ch;
      pins_t [CHANNELS-1:0] pin;
      logic [31:0]          prdata;
      logic                 pready;
      logic                 pslverr;
      logic                 irq;
   } state_t;

   // ==========================================================================
   // Reset values
   // ==========================================================================
   localparam pins_t PINS_RST = '{tx: 1'b1, general_output_two_n: 1'b1, rts_n: 1'b1, dtr_n: 1'b1,
                                  receive_ready_n: 1'b1, transmit_ready_n: 1'b0, int_out: 1'b0,
                                  int_oe: 1'b0};
   localparam chan_t CHAN_RST = '{div_low: 8'h01, line_status: 8'h60, scratchpad: 8'hff,
                                  enh_mode_select: 8'h80, default: '0};
   localparam state_t STATE_RST = '{ch: '{default: CHAN_RST}, pin: '{default: PINS_RST}, default: '0};

endpackage

// ==== dv/apb_host_model.sv ====
// APB host model that issues single register transfers to the bank.
`timescale 1ns/1ps
`default_nettype none

module apb_host_model
(
   // Clock
   input  wire logic        pclk,
   // APB request
   output var  logic        psel,
   output var  logic        penable,
   output var  logic        pwrite,
   output var  logic [11:0] paddr,
   output var  logic [31:0] pwdata,
   // APB answer
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
   end

   // The request is held until pready is sampled high or 20 cycles pass, so a slow answer is waited out up to that limit.
   task automatic xfer(input logic wr, input logic [11:0] addr, input logic [7:0] wd,
                       output logic [7:0] rd, output logic err, output logic tmo);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= {24'h000000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata[7:0];
      err = pslverr;
      tmo = (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== dv/tb_duart_channel_reset_state.sv ====
// Self-checking testbench for the dual channel register bank reset states.
`timescale 1ns/1ps
`default_nettype none

module tb_duart_channel_reset_state;
   logic                                  pclk, presetn, hw_reset_n, irq;
   logic                                  psel, penable, pwrite, pready, pslverr;
   logic [11:0]                           paddr;
   logic [31:0]                           pwdata, prdata;
   duart_reset_pkg::modem_in_t [1:0]      modem_in;
   duart_reset_pkg::pins_t [1:0]          pins;
   int                                    num_errors, checked;

   apb_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
   duart_channel_reset_state DUT (.pclk(pclk), .presetn(presetn), .hw_reset_n(hw_reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .modem_in(modem_in), .pins(pins), .irq(irq));

   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   task automatic tally_and_finish();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic access(input logic wr, input logic ch, input logic [4:0] idx, input logic [7:0] wd,
                         output logic [7:0] rd, output logic err);
      logic tmo;
      host.xfer(wr, {4'h0, ch, idx, 2'b00}, wd, rd, err, tmo);
      if (tmo)
      begin
         num_errors++;
         tally_and_finish();
      end
   endtask

   task automatic wr(input logic ch, input logic [4:0] idx, input logic [7:0] wd);
      logic [7:0] r;
      logic       e;
      access(1'b1, ch, idx, wd, r, e);
   endtask

   task automatic rd_check(input logic ch, input logic [4:0] idx, input logic [7:0] exp);
      logic [7:0] r;
      logic       e;
      access(1'b0, ch, idx, 8'h00, r, e);
      check($sformatf("reg ch%0d idx %0d", ch, idx), r, exp);
   endtask

   function automatic logic [7:0] reset_of(input logic [4:0] idx);
      case (idx)
         duart_reset_pkg::IDX_INT_SOURCE:  return 8'h01;
         duart_reset_pkg::IDX_LINE_STATUS: return 8'h60;
         duart_reset_pkg::IDX_SCRATCHPAD:  return 8'hff;
         duart_reset_pkg::IDX_DIV_LOW:     return 8'h01;
         default:                          return 8'h00;
      endcase
   endfunction

   task automatic pin_reset();
      @(posedge pclk);
      hw_reset_n <= 1'b0;
      repeat (3) @(posedge pclk);
      check("pins ch0", pins[0], duart_reset_pkg::PINS_RST);
      check("pins ch1", pins[1], duart_reset_pkg::PINS_RST);
      hw_reset_n <= 1'b1;
   endtask

   // Holding registers and write-only select are left out: their read value carries no meaning.
   task automatic reset_values();
      for (int c = 0; c < 2; c++)
      begin
         for (int i = 1; i <= 21; i++)
            if (i != 7 && i != 9 && i != 20)
               rd_check(c[0], i[4:0], reset_of(i[4:0]));
         rd_check(c[0], duart_reset_pkg::IDX_MODEM_STATUS, {~modem_in[c], 4'h0});
         check("pins", pins[c], duart_reset_pkg::PINS_RST);
      end
   endtask

   task automatic divisor_keep();
      wr(1'b0, duart_reset_pkg::IDX_DIV_LOW, 8'h1b);
      wr(1'b0, duart_reset_pkg::IDX_DIV_HIGH, 8'h02);
      wr(1'b0, duart_reset_pkg::IDX_SCRATCHPAD, 8'h5a);
      wr(1'b0, duart_reset_pkg::IDX_LINE_CONTROL, 8'h03);
      wr(1'b0, duart_reset_pkg::IDX_MODEM_CONTROL, 8'h0b);
      repeat (2) @(posedge pclk);
      check("pins driven", pins[0], 8'h89);
      pin_reset();
      rd_check(1'b0, duart_reset_pkg::IDX_DIV_LOW, 8'h1b);
      rd_check(1'b0, duart_reset_pkg::IDX_DIV_HIGH, 8'h02);
      rd_check(1'b0, duart_reset_pkg::IDX_SCRATCHPAD, 8'hff);
      rd_check(1'b0, duart_reset_pkg::IDX_LINE_CONTROL, 8'h00);
      rd_check(1'b0, duart_reset_pkg::IDX_MODEM_CONTROL, 8'h00);
      @(posedge pclk);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      rd_check(1'b0, duart_reset_pkg::IDX_DIV_LOW, 8'h01);
      rd_check(1'b0, duart_reset_pkg::IDX_DIV_HIGH, 8'h00);
   endtask

   task automatic enhanced_gate();
      wr(1'b0, duart_reset_pkg::IDX_INT_ENABLE, 8'hff);
      rd_check(1'b0, duart_reset_pkg::IDX_INT_ENABLE, 8'h0f);
      wr(1'b0, duart_reset_pkg::IDX_DIV_FRACTION, 8'h07);
      rd_check(1'b0, duart_reset_pkg::IDX_DIV_FRACTION, 8'h00);
      wr(1'b0, duart_reset_pkg::IDX_ENH_FEATURE, 8'h10);
      wr(1'b0, duart_reset_pkg::IDX_INT_ENABLE, 8'hff);
      wr(1'b0, duart_reset_pkg::IDX_MODEM_CONTROL, 8'he0);
      rd_check(1'b0, duart_reset_pkg::IDX_MODEM_CONTROL, 8'he0);
      wr(1'b0, duart_reset_pkg::IDX_ENH_FEATURE, 8'h00);
      wr(1'b0, duart_reset_pkg::IDX_INT_ENABLE, 8'h00);
      rd_check(1'b0, duart_reset_pkg::IDX_INT_ENABLE, 8'hf0);
      pin_reset();
      rd_check(1'b0, duart_reset_pkg::IDX_INT_ENABLE, 8'h00);
   endtask

   task automatic modem_events();
      logic [7:0] r;
      logic       e;
      wr(1'b1, duart_reset_pkg::IDX_EVENT_MASK, 8'h01);
      wr(1'b1, duart_reset_pkg::IDX_INT_ENABLE, 8'h08);
      modem_in[1].cts_n <= 1'b0;
      for (int n = 0; n < 10 && irq !== 1'b1; n++)
         @(posedge pclk);
      check("irq raised", irq, 8'h01);
      rd_check(1'b1, duart_reset_pkg::IDX_INT_SOURCE, 8'h00);
      rd_check(1'b1, duart_reset_pkg::IDX_MODEM_STATUS, 8'h11);
      rd_check(1'b1, duart_reset_pkg::IDX_EVENT_STATUS, 8'h01);
      repeat (2) @(posedge pclk);
      check("irq cleared", irq, 8'h00);
      wr(1'b1, duart_reset_pkg::IDX_EVENT_MASK, 8'h00);
      modem_in[1].cts_n <= 1'b1;
      repeat (6) @(posedge pclk);
      check("irq masked", irq, 8'h00);
      rd_check(1'b1, duart_reset_pkg::IDX_EVENT_STATUS, 8'h01);
      access(1'b0, 1'b0, 5'h16, 8'h00, r, e);
      check("unmapped err", e, 8'h01);
      check("unmapped data", r, 8'h00);
   endtask

   initial
   begin
      presetn = 1'b0;
      hw_reset_n = 1'b1;
      modem_in = {4'b1111, 4'b1010};
      num_errors = 0;
      checked = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      reset_values();
      divisor_keep();
      enhanced_gate();
      modem_events();
      tally_and_finish();
   end
endmodule
`default_nettype wire
